// File: design/shift_logic_regs.vh
// Register offsets, operation codes and reset values of the shift and logic unit
`ifndef SHIFT_LOGIC_REGS_VH
`define SHIFT_LOGIC_REGS_VH

// Register byte offsets
`define REG_WORK_OFF 12'h000
`define REG_FLAGS_OFF 12'h004
`define REG_OPERAND_OFF 12'h008
`define REG_CMD_OFF 12'h00C
`define REG_MEM_OFF 12'h010
`define REG_IO_OFF 12'h014
`define REG_STATUS_OFF 12'h018

// Flag register field positions
`define FLAG_ZERO_BIT 0
`define FLAG_CARRY_BIT 1
`define FLAG_HALF_BIT 2
`define FLAG_EXCESS_BIT 3

// Command register fields
`define CMD_OP_LSB 0
`define CMD_OP_MSB 4

// Reset values
`define WORK_RESET 8'h00
`define FLAGS_RESET 4'h0
`define OPERAND_RESET 8'h00
`define MEM_RESET 8'h00
`define IO_RESET 8'h00

// Operation codes
`define OP_NONE 5'h00
`define OP_SHR_W 5'h01
`define OP_RRC_W 5'h02
`define OP_SHL_W 5'h03
`define OP_RLC_W 5'h04
`define OP_SHR_M 5'h05
`define OP_RRC_M 5'h06
`define OP_SHL_M 5'h07
`define OP_RLC_M 5'h08
`define OP_SWAP_W 5'h09
`define OP_AND_WI 5'h0A
`define OP_AND_WM 5'h0B
`define OP_AND_MW 5'h0C
`define OP_OR_WI 5'h0D
`define OP_OR_WM 5'h0E
`define OP_OR_MW 5'h0F
`define OP_XOR_WI 5'h10
`define OP_XOR_WM 5'h11
`define OP_XOR_MW 5'h12
`define OP_XOR_IO 5'h13

// Shifter kinds
`define SH_RIGHT_ZERO 2'h0
`define SH_RIGHT_CARRY 2'h1
`define SH_LEFT_ZERO 2'h2
`define SH_LEFT_CARRY 2'h3

// Logic kinds
`define LG_AND 2'h0
`define LG_OR 2'h1
`define LG_XOR 2'h2

`endif

// File: design/byte_shifter.v
// One-place shifter and rotator of a byte through the carry flag
`timescale 1ns/100ps
`default_nettype none
`include "shift_logic_regs.vh"

module byte_shifter #(
    parameter WIDTH = 8
) (
    input wire [WIDTH-1:0] operand,
    input wire [1:0] kind,
    input wire carry_in,
    output reg [WIDTH-1:0] result,
    output reg carry_out
);

    always @* begin
        case (kind)
            `SH_RIGHT_ZERO: begin
                result = {1'b0, operand[WIDTH-1:1]};
                carry_out = operand[0];
            end
            `SH_RIGHT_CARRY: begin
                result = {carry_in, operand[WIDTH-1:1]};
                carry_out = operand[0];
            end
            `SH_LEFT_ZERO: begin
                result = {operand[WIDTH-2:0], 1'b0};
                carry_out = operand[WIDTH-1];
            end
            default: begin
                result = {operand[WIDTH-2:0], carry_in};
                carry_out = operand[WIDTH-1];
            end
        endcase
    end

endmodule // byte_shifter
`default_nettype wire

// File: design/byte_logic.v
// Bitwise AND, OR and exclusive OR of two bytes with a zero test
`timescale 1ns/100ps
`default_nettype none
`include "shift_logic_regs.vh"

module byte_logic #(
    parameter WIDTH = 8
) (
    input wire [WIDTH-1:0] left_operand,
    input wire [WIDTH-1:0] right_operand,
    input wire [1:0] kind,
    output reg [WIDTH-1:0] result,
    output wire is_zero
);

    always @* begin
        case (kind)
            `LG_AND: result = left_operand & right_operand;
            `LG_OR: result = left_operand | right_operand;
            default: result = left_operand ^ right_operand;
        endcase
    end

    assign is_zero = (result == {WIDTH{1'b0}});

endmodule // byte_logic
`default_nettype wire

// File: design/shift_logic_alu_unit.v
// Shift, rotate, nibble swap and bitwise logic unit behind an AHB-Lite slave
// Summary of operation
// - Logical right shift of working register fills bit 7 with zero, old bit 0 to carry.
// - Right rotate through carry puts old carry in bit 7, old bit 0 to carry.
// - Logical left shift of working register fills bit 0 with zero, old bit 7 to carry.
// - Left rotate through carry puts old carry in bit 0, old bit 7 to carry.
// - Right shift and right rotate also act on a memory byte, written back.
// - Left shift and left rotate also act on a memory byte, written back.
// - Shifts and rotates change only carry; other flags hold.
// - Nibble swap exchanges the two halves of working register, flags unchanged.
// - AND working register with immediate or memory, or into memory.
// - OR working register with immediate or memory, or into memory.
// - XOR working register with immediate or memory, or into memory.
// - Logic on memory or immediate updates zero only; other flags hold.
// - XOR into I/O register writes it back and leaves every flag unchanged.
`timescale 1ns/100ps
`default_nettype none
`include "shift_logic_regs.vh"

module shift_logic_alu_unit #(
    parameter WIDTH = 8
) (
    input wire clk,
    input wire srst,
    input wire hsel,
    input wire [11:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    output reg [WIDTH-1:0] mem_wdata,
    output reg mem_we,
    output reg [WIDTH-1:0] io_wdata,
    output reg io_we
);

    // =========================================================
    // Operation decode helpers
    // =========================================================
    function is_shift_op;
        input [4:0] op;
        begin
            is_shift_op = (op >= `OP_SHR_W) && (op <= `OP_RLC_M);
        end
    endfunction

    function [1:0] shift_kind_of;
        input [4:0] op;
        begin
            case (op)
                `OP_SHR_W, `OP_SHR_M: shift_kind_of = `SH_RIGHT_ZERO;
                `OP_RRC_W, `OP_RRC_M: shift_kind_of = `SH_RIGHT_CARRY;
                `OP_SHL_W, `OP_SHL_M: shift_kind_of = `SH_LEFT_ZERO;
                default: shift_kind_of = `SH_LEFT_CARRY;
            endcase
        end
    endfunction

    function [1:0] logic_kind_of;
        input [4:0] op;
        begin
            case (op)
                `OP_AND_WI, `OP_AND_WM, `OP_AND_MW: logic_kind_of = `LG_AND;
                `OP_OR_WI, `OP_OR_WM, `OP_OR_MW: logic_kind_of = `LG_OR;
                default: logic_kind_of = `LG_XOR;
            endcase
        end
    endfunction

    function is_mem_source;
        input [4:0] op;
        begin
            is_mem_source = (op >= `OP_SHR_M && op <= `OP_RLC_M) ||
                (op == `OP_AND_WM) || (op == `OP_AND_MW) ||
                (op == `OP_OR_WM) || (op == `OP_OR_MW) ||
                (op == `OP_XOR_WM) || (op == `OP_XOR_MW);
        end
    endfunction

    // =========================================================
    // Architectural state
    // =========================================================
    reg [WIDTH-1:0] working_register;
    reg zero_flag;
    reg carry_flag;
    reg half_carry_flag;
    reg signed_excess_flag;
    reg [WIDTH-1:0] operand_byte;
    reg [WIDTH-1:0] mem_byte;
    reg [WIDTH-1:0] io_byte;
    reg [4:0] last_op;
    reg [15:0] op_count;

    // =========================================================
    // Bus address phase capture
    // =========================================================
    reg dp_active;
    reg dp_write;
    reg [11:0] dp_addr;
    wire addr_take;

    // Only NONSEQ or SEQ with the bus ready starts a transfer
    assign addr_take = hsel && hready && htrans[1];

    always @(posedge clk) begin
        if (srst) begin
            dp_active <= 1'b0;
            dp_write <= 1'b0;
            dp_addr <= 12'h000;
        end else if (hready) begin
            dp_active <= addr_take;
            dp_write <= hwrite;
            dp_addr <= haddr;
        end
    end

    wire wr_fire;
    wire [4:0] cmd_op;
    wire cmd_fire;
    // A write lands only at the edge that ends its data phase, never twice in a wait
    assign wr_fire = dp_active && dp_write && hready;
    assign cmd_op = hwdata[`CMD_OP_MSB:`CMD_OP_LSB];
    assign cmd_fire = wr_fire && (dp_addr == `REG_CMD_OFF);

    // =========================================================
    // Datapath
    // =========================================================
    wire [WIDTH-1:0] shift_src;
    wire [WIDTH-1:0] shift_res;
    wire shift_carry;
    wire [WIDTH-1:0] logic_rhs;
    wire [WIDTH-1:0] logic_res;
    wire logic_zero;

    // Memory forms work on the staged memory byte
    assign shift_src = is_mem_source(cmd_op) ? mem_byte : working_register;

    byte_shifter #(
        .WIDTH(WIDTH)
    ) u_shifter (
        .operand(shift_src),
        .kind(shift_kind_of(cmd_op)),
        .carry_in(carry_flag),
        .result(shift_res),
        .carry_out(shift_carry)
    );

    assign logic_rhs = (cmd_op == `OP_XOR_IO) ? io_byte :
        (is_mem_source(cmd_op) ? mem_byte : operand_byte);

    byte_logic #(
        .WIDTH(WIDTH)
    ) u_logic (
        .left_operand(working_register),
        .right_operand(logic_rhs),
        .kind(logic_kind_of(cmd_op)),
        .result(logic_res),
        .is_zero(logic_zero)
    );

    // =========================================================
    // Execute and software writes
    // =========================================================
    always @(posedge clk) begin
        if (srst) begin
            working_register <= `WORK_RESET;
            {signed_excess_flag, half_carry_flag, carry_flag, zero_flag} <= `FLAGS_RESET;
            operand_byte <= `OPERAND_RESET;
            mem_byte <= `MEM_RESET;
            io_byte <= `IO_RESET;
            last_op <= `OP_NONE;
            op_count <= 16'h0000;
            mem_we <= 1'b0;
            mem_wdata <= `MEM_RESET;
            io_we <= 1'b0;
            io_wdata <= `IO_RESET;
        end else begin
            mem_we <= 1'b0;
            io_we <= 1'b0;
            if (wr_fire) begin
                case (dp_addr)
                    `REG_WORK_OFF: working_register <= hwdata[WIDTH-1:0];
                    `REG_FLAGS_OFF: begin
                        zero_flag <= hwdata[`FLAG_ZERO_BIT];
                        carry_flag <= hwdata[`FLAG_CARRY_BIT];
                        half_carry_flag <= hwdata[`FLAG_HALF_BIT];
                        signed_excess_flag <= hwdata[`FLAG_EXCESS_BIT];
                    end
                    `REG_OPERAND_OFF: operand_byte <= hwdata[WIDTH-1:0];
                    `REG_MEM_OFF: mem_byte <= hwdata[WIDTH-1:0];
                    `REG_IO_OFF: io_byte <= hwdata[WIDTH-1:0];
                    default: begin
                    end
                endcase
            end
            if (cmd_fire) begin
                last_op <= cmd_op;
                op_count <= op_count + 16'h0001;
                if (is_shift_op(cmd_op)) begin
                    carry_flag <= shift_carry;
                    if (is_mem_source(cmd_op)) begin
                        mem_byte <= shift_res;
                        mem_wdata <= shift_res;
                        mem_we <= 1'b1;
                    end else begin
                        working_register <= shift_res;
                    end
                end else begin
                    case (cmd_op)
                        `OP_SWAP_W: begin
                            working_register <= {working_register[3:0],
                                working_register[7:4]};
                        end
                        `OP_AND_WI, `OP_AND_WM, `OP_OR_WI, `OP_OR_WM,
                        `OP_XOR_WI, `OP_XOR_WM: begin
                            working_register <= logic_res;
                            zero_flag <= logic_zero;
                        end
                        `OP_AND_MW, `OP_OR_MW, `OP_XOR_MW: begin
                            mem_byte <= logic_res;
                            mem_wdata <= logic_res;
                            mem_we <= 1'b1;
                            zero_flag <= logic_zero;
                        end
                        `OP_XOR_IO: begin
                            // Port write only; flags untouched
                            io_byte <= logic_res;
                            io_wdata <= logic_res;
                            io_we <= 1'b1;
                        end
                        default: begin
                        end
                    endcase
                end
            end
        end
    end

    // =========================================================
    // Read data and response
    // =========================================================
    wire rd_take;
    wire rd_after_wr;
    wire rd_late;
    wire [11:0] rd_addr;
    reg [31:0] next_hrdata;
    assign rd_take = addr_take && !hwrite;
    // Read taken while a write is still in its data phase
    assign rd_after_wr = rd_take && dp_active && dp_write;
    // Wait cycle of such a read: sample once that write has landed
    assign rd_late = !hreadyout && dp_active && !dp_write;
    assign rd_addr = hreadyout ? haddr : dp_addr;

    always @* begin
        case (rd_addr)
            `REG_WORK_OFF: next_hrdata = {24'h000000, working_register};
            `REG_FLAGS_OFF: next_hrdata = {28'h0000000, signed_excess_flag,
                half_carry_flag, carry_flag, zero_flag};
            `REG_OPERAND_OFF: next_hrdata = {24'h000000, operand_byte};
            `REG_CMD_OFF: next_hrdata = {27'h0000000, last_op};
            `REG_MEM_OFF: next_hrdata = {24'h000000, mem_byte};
            `REG_IO_OFF: next_hrdata = {24'h000000, io_byte};
            `REG_STATUS_OFF: next_hrdata = {16'h0000, op_count};
            default: next_hrdata = 32'h00000000;
        endcase
    end

    // Read value is normally sampled at its address phase; a read right
    // behind a write would miss that write, so it gets one wait state and
    // is sampled at the end of the wait instead.
    always @(posedge clk) begin
        if (srst) begin
            hrdata <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hresp <= 1'b0;
            if (hreadyout && rd_after_wr) begin
                hreadyout <= 1'b0;
            end else begin
                hreadyout <= 1'b1;
            end
            if (rd_late) begin
                hrdata <= next_hrdata;
            end else if (rd_take && !rd_after_wr) begin
                hrdata <= next_hrdata;
            end
        end
    end

    wire unused_bits;
    assign unused_bits = ^{hsize, hwdata[31:WIDTH]};

endmodule // shift_logic_alu_unit
`default_nettype wire

// File: verification/shift_logic_chk.sv
// Port checker of the shift and logic unit
`timescale 1ns/100ps
`default_nettype none
module shift_logic_chk (
    input wire logic clk,
    input wire logic srst,
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic mem_we,
    input wire logic io_we
);
    // ==========
    // Assertions
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    sequence cmd_wr;
        hsel && hready && htrans[1] && hwrite && haddr == 12'h00C;
    endsequence
    sequence mem_op;
        hwdata[4:0] inside {[5'h05:5'h08], 5'h0C, 5'h0F, 5'h12};
    endsequence
    sequence far_read;
        hsel && hready && htrans[1] && !hwrite && haddr > 12'h018;
    endsequence
    okay_resp_a: assert property (hresp == 1'b0) else $error("response not OKAY");
    reset_quiet_a: assert property ($fell(srst) |-> hreadyout && !mem_we && !io_we
        && hrdata == 32'h0) else $error("outputs not idle after reset");
    wait_short_a: assert property (!hreadyout |=> hreadyout) else $error("wait too long");
    mem_pulse_a: assert property (mem_we |=> !mem_we) else $error("memory strobe too long");
    io_pulse_a: assert property (io_we |=> !io_we) else $error("io strobe too long");
    one_target_a: assert property (mem_we |-> !io_we) else $error("two targets");
    mem_cause_a: assert property (cmd_wr ##1 mem_op |-> ##[1:2] mem_we)
        else $error("memory result not written");
    io_cause_a: assert property (cmd_wr ##1 hwdata[4:0] == 5'h13 |-> ##[1:2] io_we)
        else $error("io result not written");
    unmapped_zero_a: assert property (far_read |=> ##[0:1] (hreadyout && hrdata == 32'h0))
        else $error("unmapped read not zero");
endmodule // shift_logic_chk
bind shift_logic_alu_unit shift_logic_chk chk_i (.clk(clk), .srst(srst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .mem_we(mem_we), .io_we(io_we));
`default_nettype wire

// File: verification/memory_side.sv
// Data memory and I/O port model that takes the unit's write-backs
`timescale 1ns/100ps
`default_nettype none
module memory_side (
    input wire logic clk,
    input wire logic srst,
    input wire logic [7:0] mem_wdata,
    input wire logic mem_we,
    input wire logic [7:0] io_wdata,
    input wire logic io_we,
    output var logic [7:0] mem_byte,
    output var logic [7:0] io_byte,
    output var logic [7:0] mem_cnt,
    output var logic [7:0] io_cnt
);
    // Counts let the bench see stray or missing strobes
    always @(posedge clk) begin
        if (srst) begin
            mem_byte <= 8'h00;
            io_byte <= 8'h00;
            mem_cnt <= 8'h00;
            io_cnt <= 8'h00;
        end else begin
            if (mem_we) begin
                mem_byte <= mem_wdata;
                mem_cnt <= mem_cnt + 8'h01;
            end
            if (io_we) begin
                io_byte <= io_wdata;
                io_cnt <= io_cnt + 8'h01;
            end
        end
    end
endmodule // memory_side
`default_nettype wire

// File: verification/shift_logic_alu_unit_tb.sv
// Self-checking bench of the shift and logic unit
`timescale 1ns/100ps
`default_nettype none
module shift_logic_alu_unit_tb;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic hsel = 1'b0;
    logic [11:0] haddr = 12'h000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    wire [31:0] hrdata;
    wire hreadyout, hresp, mem_we, io_we;
    wire [7:0] mem_wdata, io_wdata, mem_byte, io_byte, mem_cnt, io_cnt;
    int error_cnt = 0;
    int checks_done = 0;
    logic [31:0] q, e;
    logic [35:0] vec [2] = '{{8'hA5, 4'hD, 8'h5A, 8'h3C, 8'h0F}, {8'h81, 4'h2, 8'h81, 8'hC3, 8'h81}};
    logic [7:0] w, i, m, io, mc, ic;
    logic [3:0] f;
    logic [4:0] op;
    always #25 clk = ~clk;
    shift_logic_alu_unit DUT (.clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .mem_wdata(mem_wdata),
        .mem_we(mem_we), .io_wdata(io_wdata), .io_we(io_we));
    memory_side far_side (.clk(clk), .srst(srst), .mem_wdata(mem_wdata), .mem_we(mem_we),
        .io_wdata(io_wdata), .io_we(io_we), .mem_byte(mem_byte), .io_byte(io_byte),
        .mem_cnt(mem_cnt), .io_cnt(io_cnt));
    // ==========
    // Bus and compare tasks
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        q = hrdata;
        // Idle gap so a following read sees this write
        @(posedge clk);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: op %h got %h expected %h", $time, op, got, exp);
        end
    endtask
    function automatic logic is_mem(input logic [4:0] c);
        is_mem = c inside {[5'h05:5'h08], 5'h0C, 5'h0F, 5'h12};
    endfunction
    // Expected {io, memory, flags, working register} after one command
    function automatic logic [31:0] model(input logic [4:0] c, input logic [7:0] w,
        input logic [3:0] f, input logic [7:0] i, input logic [7:0] m, input logic [7:0] io);
        logic [7:0] s, o, r;
        logic cy;
        cy = f[1];
        s = (c > 5'h04) ? m : w;
        o = (c == 5'h0A || c == 5'h0D || c == 5'h10) ? i : ((c == 5'h13) ? io : m);
        r = w;
        case (c)
            5'h01, 5'h05: {r, cy} = {1'b0, s};
            5'h02, 5'h06: {r, cy} = {f[1], s};
            5'h03, 5'h07: {cy, r} = {s, 1'b0};
            5'h04, 5'h08: {cy, r} = {s, f[1]};
            5'h09: r = {w[3:0], w[7:4]};
            5'h0A, 5'h0B, 5'h0C: r = w & o;
            5'h0D, 5'h0E, 5'h0F: r = w | o;
            5'h10, 5'h11, 5'h12, 5'h13: r = w ^ o;
            default: ;
        endcase
        if (c >= 5'h01 && c <= 5'h08) f[1] = cy;
        if (c >= 5'h0A && c <= 5'h12) f[0] = (r == 8'h00);
        if (is_mem(c)) m = r;
        else if (c == 5'h13) io = r;
        else w = r;
        model = {io, m, 4'h0, f, w};
    endfunction
    task automatic test_done;
        $display("Checks %0d, errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // ==========
    // Test sequence
    initial begin
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        op = 5'h00;
        for (int a = 0; a < 9; a++) begin
            bus(1'b0, 12'(a * 4), 32'h0);
            chk(q, 32'h0);
        end
        bus(1'b1, 12'h018, 32'h0000FFFF);
        bus(1'b1, 12'h01C, 32'h000000FF);
        bus(1'b0, 12'h018, 32'h0);
        chk(q, 32'h0);
        bus(1'b0, 12'h01C, 32'h0);
        chk(q, 32'h0);
        for (int v = 0; v < 2; v++) begin
            op = 5'h00;
            repeat (21) begin
                {w, f, i, m, io} = vec[v];
                bus(1'b1, 12'h000, {24'h0, w});
                bus(1'b1, 12'h004, {28'h0, f});
                bus(1'b1, 12'h008, {24'h0, i});
                bus(1'b1, 12'h010, {24'h0, m});
                bus(1'b1, 12'h014, {24'h0, io});
                mc = mem_cnt;
                ic = io_cnt;
                bus(1'b1, 12'h00C, {27'h0, op});
                e = model(op, w, f, i, m, io);
                for (int k = 0; k < 4; k++) begin
                    bus(1'b0, 12'((k < 2) ? k * 4 : k * 4 + 8), 32'h0);
                    chk(q, {24'h0, e[k*8+:8]});
                end
                // Last command and command count read back
                bus(1'b0, 12'h00C, 32'h0);
                chk(q, {27'h0, op});
                bus(1'b0, 12'h018, 32'h0);
                chk(q, 32'(v * 21 + op + 1));
                chk({24'h0, mem_cnt - mc}, {31'h0, is_mem(op)});
                chk({24'h0, io_cnt - ic}, {31'h0, op == 5'h13});
                if (is_mem(op))
                    chk({24'h0, mem_byte}, {24'h0, e[23:16]});
                if (op == 5'h13)
                    chk({24'h0, io_byte}, {24'h0, e[31:24]});
                op++;
            end
        end
        // Reset in mid-run clears every register
        srst <= 1'b1;
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        for (int a = 0; a < 7; a++) begin
            bus(1'b0, 12'(a * 4), 32'h0);
            chk(q, 32'h0);
        end
        test_done;
    end
    initial begin
        #500000;
        error_cnt++;
        test_done;
    end
endmodule // shift_logic_alu_unit_tb
`default_nettype wire
